// file: design/lpd_map.vh
// Offsets, field positions, order codes and widths of the light pen mode control
`ifndef LPD_MAP_VH
`define LPD_MAP_VH

// Order byte codes
`define LPD_SET_MODE_BYTE      8'h2A
`define LPD_MC_GATED           8'h84
`define LPD_MC_INHIBIT         8'h85
`define LPD_MC_FREE            8'h86
`define LPD_MC_BRANCH          8'hFD

// Register byte offsets
`define LPD_REG_CTRL           4'h0
`define LPD_REG_STATUS         4'h4
`define LPD_REG_DET_X          4'h8
`define LPD_REG_DET_Y          4'hC

// Control register fields
`define LPD_CTRL_RESUME        0

// Status register fields
`define LPD_ST_ATTENTION       0
`define LPD_ST_UNIT_CHECK      1
`define LPD_ST_HALTED          2
`define LPD_ST_GATED           3
`define LPD_ST_INHIBIT         4
`define LPD_ST_FREE            5
`define LPD_ST_SYNC            6
`define LPD_ST_ACTIVE          7
`define LPD_ST_BLOCK           8
`define LPD_ST_DETECTED        9

// Widths
`define LPD_COORD_W            10
`define LPD_ADDR_W             16

// Bus answers
`define LPD_RESP_OKAY          2'b00
`define LPD_RESP_SLVERR        2'b10

`endif

// file: design/lpd_mode_ctrl.v
// Light pen detect mode control with an AXI4-Lite register slave
`timescale 1ns/1ps
`default_nettype none
`include "lpd_map.vh"

// What this block does
// RQ1 - Gated detect needs closure, then restart, then mode
// RQ2 - One gated detect per tip switch closure
// RQ3 - Gated mode ends only on free or inhibit
// RQ4 - Gated order or restart re-enters gated mode
// RQ5 - Gated detect halts, raises attention and unit check
// RQ6 - Detected beam coordinates held for host reading
// RQ7 - Inhibit suppresses detects until enabling order
// RQ8 - Inhibit order clears gated and free modes
// RQ9 - Free mode detects on any viewed item
// RQ10 - Free detect leaves switch latches untouched
// RQ11 - Free mode ends on restart, gated, inhibit
// RQ12 - Free detect halts, raises attention and unit check
// RQ13 - Free detect blocks branch until restart or gated
// RQ14 - Free mode preserves gated sync and transfer state
// RQ15 - Branch taken when gated conditions met undetected
// RQ16 - Branch taken in free mode without detect
// RQ17 - Orders are set-mode byte plus mode code
// RQ18 - Unmet branch is a four-byte no-operation
module lpd_mode_ctrl (
   input  wire                     aclk,
   input  wire                     aresetn,
   // Order stream from the display order decoder
   input  wire                     order_valid,
   input  wire [7:0]               order_byte,
   input  wire                     regen_timer_restart_order,
   // Light pen
   input  wire                     pen_tip_switch,
   input  wire                     pen_sense,
   // Present beam position
   input  wire [`LPD_COORD_W-1:0]  beam_x,
   input  wire [`LPD_COORD_W-1:0]  beam_y,
   // Regeneration control
   output reg                      regen_halt,
   output reg                      pen_detect,
   output reg                      branch_take,
   output reg                      branch_noop,
   output reg  [`LPD_ADDR_W-1:0]   branch_target,
   // AXI4-Lite slave
   input  wire [3:0]               s_axi_awaddr,
   input  wire                     s_axi_awvalid,
   output reg                      s_axi_awready,
   input  wire [31:0]              s_axi_wdata,
   input  wire [3:0]               s_axi_wstrb,
   input  wire                     s_axi_wvalid,
   output reg                      s_axi_wready,
   output reg  [1:0]               s_axi_bresp,
   output reg                      s_axi_bvalid,
   input  wire                     s_axi_bready,
   input  wire [3:0]               s_axi_araddr,
   input  wire                     s_axi_arvalid,
   output reg                      s_axi_arready,
   output reg  [31:0]              s_axi_rdata,
   output reg  [1:0]               s_axi_rresp,
   output reg                      s_axi_rvalid,
   input  wire                     s_axi_rready
);

   // Decoded order pulses
   wire                   gated_ord;      // Switch-gated detect order
   wire                   inhibit_ord;    // Detect inhibit order
   wire                   free_ord;       // Free-running detect order
   wire                   branch_ord;     // Branch-if-undetected order complete
   wire [`LPD_ADDR_W-1:0] branch_addr;    // Branch target from bytes three and four

   // Mode and latch state
   reg                    gated_mode;     // Switch-gated detect mode
   reg                    inhibit_mode;   // Detects suppressed
   reg                    free_mode;      // Free-running detect mode
   reg                    pen_switch_sync_latch;   // Closure seen, awaiting restart
   reg                    pen_switch_active_latch; // Restart followed closure
   reg                    switch_prev;    // Tip switch of the last cycle
   reg                    branch_block;   // Branch blocked after free detect
   reg                    detected;       // A detect occurred since the last restart, gated order or free order
   reg                    attention;      // Sticky attention status
   reg                    unit_check;     // Sticky unit check status
   reg [`LPD_COORD_W-1:0] det_x;          // Beam X at the detect
   reg [`LPD_COORD_W-1:0] det_y;          // Beam Y at the detect

   // Detect qualifiers
   wire switch_closed_edge;               // Tip switch has just closed
   wire restart;                          // Restart order decoded
   wire gated_hit;                        // Permitted gated detect
   wire free_hit;                         // Permitted free detect
   wire any_hit;                          // Either detect
   wire cond_gated;                       // Gated branch conditions
   wire cond_free;                        // Free branch conditions

   // Bus handshake terms
   wire        wr_go;                     // Write address and data taken
   wire        rd_go;                     // Read address taken
   wire        clr_attention;             // Software clears attention
   wire        clr_unit_check;            // Software clears unit check
   wire        resume;                    // Software releases regeneration
   reg  [31:0] next_rdata;                // Read data for the taken address
   reg  [1:0]  next_rresp;                // Read answer for the taken address

   // Order byte decoder
   lpd_order_decode u_decode (
      .aclk        (aclk),
      .aresetn     (aresetn),
      .order_valid (order_valid),
      .order_byte  (order_byte),
      .gated_ord   (gated_ord),
      .inhibit_ord (inhibit_ord),
      .free_ord    (free_ord),
      .branch_ord  (branch_ord),
      .branch_addr (branch_addr)
   );

   assign restart            = regen_timer_restart_order;
   assign switch_closed_edge = pen_tip_switch & ~switch_prev;

   // Gated detect needs both latches, gated mode and a running display
   assign gated_hit = gated_mode & ~inhibit_mode & pen_switch_active_latch
                      & pen_sense & ~regen_halt; // [RQ1] [RQ7]
   // Free detect ignores the tip switch and restart sync
   assign free_hit  = free_mode & ~inhibit_mode & pen_sense & ~regen_halt; // [RQ9] [RQ7]
   assign any_hit   = gated_hit | free_hit;

   // Branch conditions, evaluated when the four-byte order completes
   assign cond_gated = gated_mode & pen_switch_sync_latch
                       & pen_switch_active_latch & ~detected; // [RQ15]
   assign cond_free  = free_mode & ~branch_block & ~detected; // [RQ16] [RQ13]

   // Tip switch history for closure detection
   always @(posedge aclk) begin
      if (!aresetn) begin
         switch_prev <= 1'b0;
      end else begin
         switch_prev <= pen_tip_switch;
      end
   end

   // Mode register: each order sets its own mode and clears the rivals
   always @(posedge aclk) begin
      if (!aresetn) begin
         gated_mode   <= 1'b1;
         inhibit_mode <= 1'b0;
         free_mode    <= 1'b0;
      end else if (gated_ord || restart) begin
         // Gated order or restart re-enters gated mode
         gated_mode   <= 1'b1; // [RQ4]
         inhibit_mode <= 1'b0; // [RQ7]
         free_mode    <= 1'b0; // [RQ11]
      end else if (inhibit_ord) begin
         gated_mode   <= 1'b0; // [RQ8] [RQ3]
         inhibit_mode <= 1'b1; // [RQ7]
         free_mode    <= 1'b0; // [RQ8] [RQ11]
      end else if (free_ord) begin
         gated_mode   <= 1'b0; // [RQ9] [RQ3]
         inhibit_mode <= 1'b0; // [RQ9]
         free_mode    <= 1'b1; // [RQ9]
      end
   end

   // Switch latches; free mode leaves them alone so gated state survives [RQ10] [RQ14]
   always @(posedge aclk) begin
      if (!aresetn) begin
         pen_switch_sync_latch   <= 1'b0;
         pen_switch_active_latch <= 1'b0;
      end else if (!pen_tip_switch) begin
         // An open switch ends the closure
         pen_switch_sync_latch   <= 1'b0; // [RQ2]
         pen_switch_active_latch <= 1'b0; // [RQ2]
      end else if (gated_hit) begin
         // One gated detect per closure
         pen_switch_sync_latch   <= 1'b0; // [RQ2]
         pen_switch_active_latch <= 1'b0; // [RQ2]
      end else if (branch_ord && cond_gated) begin
         // A taken gated branch also uses up the closure
         pen_switch_sync_latch   <= 1'b0; // [RQ15]
         pen_switch_active_latch <= 1'b0; // [RQ15]
      end else begin
         if (switch_closed_edge) begin
            pen_switch_sync_latch <= 1'b1; // [RQ1]
         end
         // Restart after the closure arms the pen
         if (restart && pen_switch_sync_latch) begin
            pen_switch_active_latch <= 1'b1; // [RQ1]
         end
      end
   end

   // Branch block and detect history
   always @(posedge aclk) begin
      if (!aresetn) begin
         branch_block <= 1'b0;
         detected     <= 1'b0;
      end else begin
         if (free_hit) begin
            branch_block <= 1'b1; // [RQ13]
         end else if (restart || gated_ord) begin
            branch_block <= 1'b0; // [RQ13]
         end
         if (any_hit) begin
            detected <= 1'b1;
         end else if (restart || gated_ord || free_ord) begin
            detected <= 1'b0;
         end
      end
   end

   // Halt, detect pulse and coordinate capture; the halt freezes the scene
   always @(posedge aclk) begin
      if (!aresetn) begin
         regen_halt <= 1'b0;
         pen_detect <= 1'b0;
         det_x      <= 10'h000;
         det_y      <= 10'h000;
      end else begin
         pen_detect <= any_hit;
         if (any_hit) begin
            regen_halt <= 1'b1;   // [RQ5] [RQ12]
            det_x      <= beam_x; // [RQ6]
            det_y      <= beam_y; // [RQ6]
         end else if (resume) begin
            regen_halt <= 1'b0;
         end
      end
   end

   // Branch answer to the order sequencer
   always @(posedge aclk) begin
      if (!aresetn) begin
         branch_take   <= 1'b0;
         branch_noop   <= 1'b0;
         branch_target <= 16'h0000;
      end else begin
         branch_take <= branch_ord & (cond_gated | cond_free); // [RQ15] [RQ16]
         branch_noop <= branch_ord & ~(cond_gated | cond_free); // [RQ18]
         if (branch_ord) begin
            branch_target <= branch_addr; // [RQ15]
         end
      end
   end

   // Interrupt status; a new detect wins over a clear in the same cycle
   always @(posedge aclk) begin
      if (!aresetn) begin
         attention  <= 1'b0;
         unit_check <= 1'b0;
      end else begin
         if (any_hit) begin
            attention <= 1'b1; // [RQ5] [RQ12]
         end else if (clr_attention) begin
            attention <= 1'b0;
         end
         if (any_hit) begin
            unit_check <= 1'b1; // [RQ5] [RQ12]
         end else if (clr_unit_check) begin
            unit_check <= 1'b0;
         end
      end
   end

   // Write side: take address and data together, answer one cycle later
   assign wr_go = s_axi_awvalid & s_axi_wvalid & s_axi_awready & s_axi_wready;
   assign resume = wr_go & (s_axi_awaddr == `LPD_REG_CTRL) & s_axi_wstrb[0]
                   & s_axi_wdata[`LPD_CTRL_RESUME];
   assign clr_attention  = wr_go & (s_axi_awaddr == `LPD_REG_STATUS) & s_axi_wstrb[0]
                           & s_axi_wdata[`LPD_ST_ATTENTION];
   assign clr_unit_check = wr_go & (s_axi_awaddr == `LPD_REG_STATUS) & s_axi_wstrb[0]
                           & s_axi_wdata[`LPD_ST_UNIT_CHECK];

   always @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= `LPD_RESP_OKAY;
      end else begin
         // Ready pulses only when both halves wait and no answer is pending
         s_axi_awready <= s_axi_awvalid & s_axi_wvalid & ~s_axi_awready
                          & ~s_axi_bvalid;
         s_axi_wready  <= s_axi_awvalid & s_axi_wvalid & ~s_axi_awready
                          & ~s_axi_bvalid;
         if (wr_go) begin
            s_axi_bvalid <= 1'b1;
            if (s_axi_awaddr == `LPD_REG_CTRL || s_axi_awaddr == `LPD_REG_STATUS) begin
               s_axi_bresp <= `LPD_RESP_OKAY;
            end else begin
               // Coordinate registers are read only, others unmapped
               s_axi_bresp <= `LPD_RESP_SLVERR;
            end
         end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // Read data selection
   always @* begin
      next_rdata = 32'h0000_0000;
      next_rresp = `LPD_RESP_OKAY;
      case (s_axi_araddr)
         `LPD_REG_CTRL: begin
            next_rdata = 32'h0000_0000;
         end
         `LPD_REG_STATUS: begin
            next_rdata[`LPD_ST_ATTENTION]  = attention;
            next_rdata[`LPD_ST_UNIT_CHECK] = unit_check;
            next_rdata[`LPD_ST_HALTED]     = regen_halt;
            next_rdata[`LPD_ST_GATED]      = gated_mode;
            next_rdata[`LPD_ST_INHIBIT]    = inhibit_mode;
            next_rdata[`LPD_ST_FREE]       = free_mode;
            next_rdata[`LPD_ST_SYNC]       = pen_switch_sync_latch;
            next_rdata[`LPD_ST_ACTIVE]     = pen_switch_active_latch;
            next_rdata[`LPD_ST_BLOCK]      = branch_block;
            next_rdata[`LPD_ST_DETECTED]   = detected;
         end
         `LPD_REG_DET_X: begin
            next_rdata[`LPD_COORD_W-1:0] = det_x; // [RQ6]
         end
         `LPD_REG_DET_Y: begin
            next_rdata[`LPD_COORD_W-1:0] = det_y; // [RQ6]
         end
         default: begin
            next_rresp = `LPD_RESP_SLVERR;
         end
      endcase
   end

   // Read side: address taken, data one cycle later
   assign rd_go = s_axi_arvalid & s_axi_arready;

   always @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h0000_0000;
         s_axi_rresp   <= `LPD_RESP_OKAY;
      end else begin
         s_axi_arready <= s_axi_arvalid & ~s_axi_arready & ~s_axi_rvalid;
         if (rd_go) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= next_rdata;
            s_axi_rresp  <= next_rresp;
         end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

endmodule // lpd_mode_ctrl
`default_nettype wire

// file: design/lpd_order_decode.v
// Order byte decoder: set-mode byte, mode-code byte and branch address bytes
`timescale 1ns/1ps
`default_nettype none
`include "lpd_map.vh"

module lpd_order_decode (
   input  wire                     aclk,
   input  wire                     aresetn,
   input  wire                     order_valid,
   input  wire [7:0]               order_byte,
   output reg                      gated_ord,
   output reg                      inhibit_ord,
   output reg                      free_ord,
   output reg                      branch_ord,
   output reg  [`LPD_ADDR_W-1:0]   branch_addr
);

   // Decoder states
   localparam [1:0] ST_IDLE = 2'd0;   // Waiting for a set-mode byte
   localparam [1:0] ST_MODE = 2'd1;   // Waiting for the mode-code byte
   localparam [1:0] ST_AHI  = 2'd2;   // Waiting for address byte three
   localparam [1:0] ST_ALO  = 2'd3;   // Waiting for address byte four

   reg [1:0] state;                   // Current decoder state

   // Byte sequencer; every order output is a one-cycle pulse
   always @(posedge aclk) begin
      gated_ord   <= 1'b0;
      inhibit_ord <= 1'b0;
      free_ord    <= 1'b0;
      branch_ord  <= 1'b0;
      if (!aresetn) begin
         state       <= ST_IDLE;
         branch_addr <= 16'h0000;
      end else if (order_valid) begin
         case (state)
            ST_IDLE: begin
               // Two-byte orders start with the set-mode byte
               if (order_byte == `LPD_SET_MODE_BYTE) begin // [RQ17]
                  state <= ST_MODE;
               end
            end
            ST_MODE: begin
               state <= ST_IDLE;
               case (order_byte)
                  `LPD_MC_GATED:   gated_ord   <= 1'b1; // [RQ17]
                  `LPD_MC_INHIBIT: inhibit_ord <= 1'b1; // [RQ17]
                  `LPD_MC_FREE:    free_ord    <= 1'b1; // [RQ17]
                  `LPD_MC_BRANCH:  state       <= ST_AHI; // [RQ17]
                  default: begin
                     // Another mode code, not ours
                     if (order_byte == `LPD_SET_MODE_BYTE) begin
                        state <= ST_MODE;
                     end
                  end
               endcase
            end
            ST_AHI: begin
               // Byte three is the high half of the target
               branch_addr[15:8] <= order_byte; // [RQ17]
               state             <= ST_ALO;
            end
            ST_ALO: begin
               // Byte four completes the branch order
               branch_addr[7:0] <= order_byte; // [RQ17]
               branch_ord       <= 1'b1;
               state            <= ST_IDLE;
            end
            default: begin
               state <= ST_IDLE;
            end
         endcase
      end
   end

endmodule // lpd_order_decode
`default_nettype wire

// file: testbench/lpd_mode_ctrl_asserts.sv
// Concurrent checks on the light pen mode control ports
`timescale 1ns/1ps
`default_nettype none
`include "lpd_map.vh"

module lpd_mode_ctrl_asserts (
   input wire logic       aclk,
   input wire logic       aresetn,
   input wire logic       order_valid,
   input wire logic [7:0] order_byte,
   input wire logic       regen_timer_restart_order,
   input wire logic       pen_sense,
   input wire logic       regen_halt,
   input wire logic       pen_detect,
   input wire logic       branch_take,
   input wire logic       branch_noop,
   input wire logic       s_axi_awvalid,
   input wire logic       s_axi_awready,
   input wire logic       s_axi_wvalid,
   input wire logic       s_axi_bvalid,
   input wire logic       s_axi_bready,
   input wire logic       s_axi_rvalid,
   input wire logic       s_axi_rready
);
   reg       sm_seen;   // Last order byte was a set-mode byte
   reg [7:0] mode;      // Mode code last decoded
   reg [2:0] age;       // Cycles since the mode last changed, saturating

   // Shadow of the detect mode, taken from the order stream
   always @(posedge aclk) begin
      if (!aresetn) begin
         sm_seen <= 1'b0;
         mode    <= `LPD_MC_GATED;
         age     <= 3'h0;
      end else begin
         if (order_valid) sm_seen <= (order_byte == `LPD_SET_MODE_BYTE);
         if (order_valid && sm_seen && order_byte >= `LPD_MC_GATED &&
             order_byte <= `LPD_MC_FREE) begin
            mode <= order_byte;
            age  <= 3'h0;
         end else if (regen_timer_restart_order) begin
            mode <= `LPD_MC_GATED;
            age  <= 3'h0;
         end else if (age != 3'h7) begin
            age <= age + 3'h1;
         end
      end
   end

   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   a_detect_halts: assert property (pen_detect |-> regen_halt)
      else $error("detect without halt");
   a_detect_single: assert property (regen_halt |=> !pen_detect)
      else $error("detect while halted");
   a_detect_cause: assert property (pen_detect |-> $past(pen_sense) && !$past(regen_halt))
      else $error("detect without pen sense");
   a_halt_holds: assert property (regen_halt && !s_axi_awvalid && !s_axi_wvalid |=> regen_halt)
      else $error("halt dropped without resume");
   a_inhibit_quiet: assert property (mode == `LPD_MC_INHIBIT && age >= 3'h3 |-> !pen_detect)
      else $error("detect while inhibited");
   a_free_detects: assert property (mode == `LPD_MC_FREE && age >= 3'h3 && pen_sense && !regen_halt
      |=> pen_detect)
      else $error("free mode missed a detect");
   a_branch_after_byte: assert property (branch_take || branch_noop |-> $past(order_valid, 2))
      else $error("branch answer without order byte");
   a_branch_once: assert property (branch_take || branch_noop
      |-> !(branch_take && branch_noop) ##1 !(branch_take || branch_noop))
      else $error("branch answer not a single pulse");
   a_write_resp_holds: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
      else $error("write response dropped");
   a_read_resp_holds: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid)
      else $error("read response dropped");

   c_detect: cover property (pen_detect);
   c_take:   cover property (branch_take);
   c_noop:   cover property (branch_noop);
endmodule // lpd_mode_ctrl_asserts

bind lpd_mode_ctrl lpd_mode_ctrl_asserts lpd_mode_ctrl_asserts_i (.*);

`default_nettype wire

// file: testbench/lpd_pen_model.sv
// Light pen with tip switch, as seen from the mode control block
`timescale 1ns/1ps
`default_nettype none

module lpd_pen_model (
   input  wire logic aclk,
   input  wire logic aresetn,
   input  wire logic closed_req,
   input  wire logic view_req,
   output var  logic pen_tip_switch,
   output var  logic pen_sense
);
   // Switch follows the request, sense is a one-cycle glimpse of an item
   always @(posedge aclk) begin
      if (!aresetn) begin
         pen_tip_switch <= 1'b0;
         pen_sense      <= 1'b0;
      end else begin
         pen_tip_switch <= closed_req;
         pen_sense      <= view_req;
      end
   end
endmodule // lpd_pen_model

`default_nettype wire

// file: testbench/tb.sv
// Self-checking bench for the light pen mode control
`timescale 1ns/1ps
`default_nettype none
`include "lpd_map.vh"

module tb;
   logic aclk = 1'b0, aresetn = 1'b0, closed_req = 1'b0, view_req = 1'b0;
   logic order_valid = 1'b0, regen_timer_restart_order = 1'b0;
   logic [7:0] order_byte = 8'h00;
   logic [`LPD_COORD_W-1:0] beam_x = 10'h000, beam_y = 10'h000;
   logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hF;
   logic [31:0] s_axi_wdata = 32'h0000_0000;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   wire pen_tip_switch, pen_sense, regen_halt, pen_detect, branch_take, branch_noop;
   wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   wire [1:0] s_axi_bresp, s_axi_rresp;
   wire [15:0] branch_target;
   wire [31:0] s_axi_rdata;
   int failures = 0, compares = 0, det_cnt = 0, take_cnt = 0, noop_cnt = 0;
   logic [31:0] d;   // Last read data
   logic [1:0]  r;   // Last response code

   lpd_mode_ctrl lpd_mode_ctrl_i (.*);
   lpd_pen_model lpd_pen_model_i (.*);

   // Clock at 100 MHz
   initial forever #5 aclk = ~aclk;

   // Pulse counters
   always @(posedge aclk) begin
      if (pen_detect === 1'b1) det_cnt++;
      if (branch_take === 1'b1) take_cnt++;
      if (branch_noop === 1'b1) noop_cnt++;
   end

   task automatic chk(input logic [31:0] seen, exp);
      compares++;
      if (seen !== exp) begin
         failures++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic tick(input int n);
      repeat (n) @(posedge aclk);
   endtask

   // Write one word, each channel held until taken
   task automatic wr(input logic [3:0] a, input logic [31:0] v);
      s_axi_awaddr <= a;
      s_axi_wdata <= v;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (!s_axi_bvalid);
      r = s_axi_bresp;
      s_axi_bready <= 1'b0;
      tick(1);
   endtask

   // Read one word
   task automatic rd(input logic [3:0] a);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (!s_axi_rvalid);
      d = s_axi_rdata;
      r = s_axi_rresp;
      s_axi_rready <= 1'b0;
      tick(1);
   endtask

   task automatic st(input logic [31:0] mask, exp);
      rd(`LPD_REG_STATUS);
      chk(d & mask, exp);
   endtask

   // Order bytes, most significant first
   task automatic send(input logic [31:0] w, input int n);
      for (int i = 0; i < n; i++) begin
         order_valid <= 1'b1;
         order_byte <= w[31-8*i -: 8];
         tick(1);
      end
      order_valid <= 1'b0;
      tick(4);
   endtask

   task automatic restart;
      regen_timer_restart_order <= 1'b1;
      tick(1);
      regen_timer_restart_order <= 1'b0;
      tick(4);
   endtask

   task automatic view;
      view_req <= 1'b1;
      tick(1);
      view_req <= 1'b0;
      tick(6);
   endtask

   task automatic sw(input logic v);
      closed_req <= v;
      tick(5);
   endtask

   task automatic resume;
      wr(`LPD_REG_CTRL, 32'h0000_0001);
      wr(`LPD_REG_STATUS, 32'h0000_0003);
   endtask

   task automatic t_reset;
      st(32'hFFFF_FFFF, 32'h0000_0008);
      rd(4'h2);
      chk(r, `LPD_RESP_SLVERR);
      wr(`LPD_REG_DET_X, 32'h0000_0055);
      chk(r, `LPD_RESP_SLVERR);
      rd(`LPD_REG_DET_X);
      chk(d, 32'h0000_0000);
   endtask

   task automatic t_gated;
      det_cnt = 0;
      beam_x <= 10'h123;
      beam_y <= 10'h2AB;
      view();
      chk(det_cnt, 0);
      sw(1'b1);
      view();
      chk(det_cnt, 0);
      restart();
      view();
      chk(det_cnt, 1);
      st(32'hFFFF_FFFF, 32'h0000_020F);
      rd(`LPD_REG_DET_X);
      chk(d, 32'h0000_0123);
      rd(`LPD_REG_DET_Y);
      chk(d, 32'h0000_02AB);
      resume();
      restart();
      view();
      chk(det_cnt, 1);
      sw(1'b0);
      sw(1'b1);
      restart();
      view();
      chk(det_cnt, 2);
      resume();
   endtask

   task automatic t_inhibit;
      det_cnt = 0;
      send(32'h2A2A_8500, 3);
      st(32'h0000_0038, 32'h0000_0010);
      sw(1'b0);
      sw(1'b1);
      view();
      chk(det_cnt, 0);
      send(32'h2A84_0000, 2);
      st(32'h0000_0038, 32'h0000_0008);
      restart();
      view();
      chk(det_cnt, 1);
      resume();
   endtask

   task automatic t_free;
      det_cnt = 0;
      sw(1'b0);
      send(32'h2A86_0000, 2);
      st(32'h0000_0038, 32'h0000_0020);
      view();
      chk(det_cnt, 1);
      st(32'h0000_0107, 32'h0000_0107);
      resume();
      view();
      chk(det_cnt, 2);
      resume();
      send(32'h2AFD_BEEF, 4);
      chk({take_cnt[15:0], noop_cnt[15:0]}, 32'h0000_0001);
      restart();
      st(32'h0000_0138, 32'h0000_0008);
   endtask

   task automatic t_keep;
      det_cnt = 0;
      sw(1'b1);
      restart();
      send(32'h2A86_0000, 2);
      view();
      chk(det_cnt, 1);
      st(32'h0000_00C0, 32'h0000_00C0);
      resume();
      send(32'h2A84_0000, 2);
      view();
      chk(det_cnt, 2);
      resume();
   endtask

   task automatic t_branch;
      take_cnt = 0;
      noop_cnt = 0;
      sw(1'b0);
      sw(1'b1);
      restart();
      send(32'h2AFD_BEEF, 4);
      chk({take_cnt[15:0], noop_cnt[15:0]}, 32'h0001_0000);
      chk(branch_target, 32'h0000_BEEF);
      send(32'h2AFD_BEEF, 4);
      chk({take_cnt[15:0], noop_cnt[15:0]}, 32'h0001_0001);
      sw(1'b0);
      send(32'h2A86_0000, 2);
      send(32'h2AFD_1234, 4);
      chk({take_cnt[15:0], noop_cnt[15:0]}, 32'h0002_0001);
      chk(branch_target, 32'h0000_1234);
   endtask

   task automatic conclude;
      if (failures == 0 && compares > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask

   // Main sequence
   initial begin
      repeat (20) @(posedge aclk);
      aresetn <= 1'b1;
      tick(1);
      t_reset();
      t_gated();
      t_inhibit();
      t_free();
      t_keep();
      t_branch();
      conclude();
   end

   // Watchdog against a hung handshake
   initial begin
      #200_000;
      failures++;
      conclude();
   end
endmodule // tb

`default_nettype wire
